// File: core/ssp_pkg.sv
// shared constants and types of the synchronous serial port controller
package ssp_pkg;
   localparam int SSP_DATA_W = 16;
   localparam int SSP_FIFO_DEPTH = 8;
   localparam logic [3:0] SSP_WIDTH_MIN_M1 = 4'h3;
   localparam logic [3:0] SSP_WIDTH_MAX_M1 = 4'hf;
   localparam logic [7:0] SSP_EOF_HI_CLEAR = 8'h00;
   // interrupt status bit positions
   localparam int SSP_INT_TXH = 0;
   localparam int SSP_INT_RXH = 1;
   localparam int SSP_INT_OVR = 2;
   localparam int SSP_INT_EOT = 3;
   // values after reset
   localparam logic [3:0] SSP_INT_RST = 4'h1;
   localparam logic SSP_FS_IDLE = 1'b1;
   localparam logic SSP_TX_READY_RST = 1'b1;

   typedef enum logic [1:0] {
      SSP_FMT_SPI = 2'h0,
      SSP_FMT_SYNC = 2'h1,
      SSP_FMT_MW = 2'h2
   } ssp_fmt_t;

   typedef enum logic [2:0] {
      SSP_ADV_LEGACY = 3'h0,
      SSP_ADV_WRITE = 3'h1,
      SSP_ADV_RW = 3'h2,
      SSP_ADV_BI_RD = 3'h3,
      SSP_ADV_BI_WR = 3'h4,
      SSP_ADV_QD_RD = 3'h5,
      SSP_ADV_QD_WR = 3'h6
   } ssp_adv_t;

   typedef enum logic [1:0] {
      SSP_IDLE = 2'h0,
      SSP_PRE = 2'h1,
      SSP_SHIFT = 2'h3,
      SSP_GAP = 2'h2
   } ssp_state_t;

   typedef struct packed {
      ssp_fmt_t fmt;
      logic cpol;
      logic cpha;
      logic slave;
      logic slave_out_dis;
      logic [3:0] width_m1;
      logic [7:0] prescale;
      logic [7:0] divider;
      logic bit_clock_from_internal_osc;
      logic frame_hold;
      ssp_adv_t adv;
   } ssp_cfg_t;

   typedef struct packed {
      logic [SSP_DATA_W-1:0] data;
      logic eof;
      ssp_adv_t adv;
   } ssp_txe_t;

   typedef struct packed {
      logic sclk;
      logic frame_select_pin;
      logic [3:0] dat;
   } ssp_pin_in_t;

   typedef struct packed {
      logic sclk;
      logic sclk_oe;
      logic frame_select_pin;
      logic frame_select_pin_oe;
      logic [3:0] dat;
      logic [3:0] dat_oe;
   } ssp_pin_out_t;
endpackage

// File: core/ssp_ctrl.sv
// synchronous serial port controller: fifos, bit clock, master and slave shifter
`timescale 1ns/100ps
module ssp_ctrl
   import ssp_pkg::*;
#(
   parameter int DEPTH = SSP_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // control and configuration
   input wire logic en,
   input wire ssp_cfg_t cfg,
   input wire logic precision_internal_oscillator_tick,
   input wire logic dma_tx_en,
   input wire logic dma_rx_en,
   input wire logic [3:0] int_mask,
   input wire logic [3:0] int_clear,
   // transmit words
   input wire logic tx_valid,
   input wire logic [SSP_DATA_W-1:0] tx_data,
   input wire logic tx_eof,
   output logic tx_ready,
   // receive words
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [SSP_DATA_W-1:0] rx_data,
   // status
   output logic busy,
   output logic [3:0] raw_status,
   output logic [3:0] masked_status,
   output logic irq,
   output logic dma_tx_req,
   output logic dma_rx_req,
   // serial pins
   input wire ssp_pin_in_t pin_i,
   output ssp_pin_out_t pin_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_HALF = (AW+1)'(DEPTH / 2);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("ssp_ctrl: DEPTH must be a power of two of at least 2");
   end

   typedef struct packed {
      ssp_state_t st;
      ssp_txe_t [DEPTH-1:0] txq;
      logic [AW:0] txw;
      logic [AW:0] txr;
      logic [DEPTH-1:0][SSP_DATA_W-1:0] rxq;
      logic [AW:0] rxw;
      logic [AW:0] rxr;
      ssp_txe_t cur;
      logic [SSP_DATA_W-1:0] sh;
      logic [SSP_DATA_W-1:0] rsh;
      logic [4:0] cnt;
      logic half;
      logic sact;
      logic [6:0] pre;
      logic [7:0] scr;
      logic sclk_d;
      logic [3:0] raw;
      logic [3:0] masked;
      logic irq;
      logic tx_ready;
      logic rx_valid;
      logic [SSP_DATA_W-1:0] rx_data;
      logic busy;
      logic dma_tx;
      logic dma_rx;
      ssp_pin_out_t pins;
   } ssp_state_all_t;

   ssp_state_all_t q;
   ssp_state_all_t n;
   logic [AW-1:0] wr_idx;

   function automatic logic [2:0] f_step(input ssp_adv_t a);
      case (a)
         SSP_ADV_BI_RD, SSP_ADV_BI_WR: f_step = 3'h2;
         SSP_ADV_QD_RD, SSP_ADV_QD_WR: f_step = 3'h4;
         default: f_step = 3'h1;
      endcase
   endfunction

   function automatic logic f_rx_off(input ssp_adv_t a);
      f_rx_off = (a == SSP_ADV_WRITE) || (a == SSP_ADV_BI_WR) || (a == SSP_ADV_QD_WR);
   endfunction

   function automatic logic f_tx_off(input ssp_adv_t a);
      f_tx_off = (a == SSP_ADV_BI_RD) || (a == SSP_ADV_QD_RD);
   endfunction

   assign wr_idx = q.txw[AW-1:0];

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      logic tick;
      logic load;
      logic tx_empty;
      logic rx_push;
      logic gap;
      logic pol;
      logic pha;
      logic samp;
      logic sedge;
      logic [SSP_DATA_W-1:0] rx_word;
      logic [3:0] wm1;
      logic [4:0] bits;
      logic [2:0] step;
      logic [3:0] rx_bits;
      logic [6:0] pre_top;
      ssp_txe_t ent;
      ssp_txe_t wr;
      tick = 1'b0;
      load = 1'b0;
      rx_push = 1'b0;
      gap = 1'b0;
      rx_word = '0;
      samp = 1'b0;
      sedge = 1'b0;
      wr = '0;
      n = q;
      n.sclk_d = pin_i.sclk;
      tx_empty = (q.txw == q.txr);
      ent = q.txq[q.txr[AW-1:0]];
      wm1 = (cfg.width_m1 < SSP_WIDTH_MIN_M1) ? SSP_WIDTH_MIN_M1 : cfg.width_m1;
      bits = {1'b0, wm1} + 5'h1;
      step = f_step(q.cur.adv);
      // sync-pulse format always shifts on rising, samples on falling
      pol = (cfg.fmt == SSP_FMT_SPI) ? cfg.cpol : 1'b0;
      pha = (cfg.fmt == SSP_FMT_SYNC) ? 1'b1 : ((cfg.fmt == SSP_FMT_SPI) ? cfg.cpha : 1'b0);
      case (step)
         3'h2: rx_bits = {2'h0, pin_i.dat[1:0]};
         3'h4: rx_bits = pin_i.dat;
         default: rx_bits = {3'h0, pin_i.dat[1]};
      endcase
      // -------------------------------------------------------------
      // bit clock: half-bit tick every max(prescale/2,1)*(divider+1) base ticks
      // -------------------------------------------------------------
      pre_top = (cfg.prescale[7:1] == 7'h00) ? 7'h00 : cfg.prescale[7:1] - 7'h01;
      if (q.st != SSP_IDLE && (!cfg.bit_clock_from_internal_osc || precision_internal_oscillator_tick)) begin
         if (q.pre >= pre_top) begin
            n.pre = '0;
            if (q.scr >= cfg.divider) begin
               n.scr = '0;
               tick = 1'b1;
            end else begin
               n.scr = q.scr + 8'h01;
            end
         end else begin
            n.pre = q.pre + 7'h01;
         end
      end
      // -------------------------------------------------------------
      // master and slave shifters
      // -------------------------------------------------------------
      if (!en) begin
         n.st = SSP_IDLE;
         n.half = 1'b0;
         n.sact = 1'b0;
         n.pre = '0;
         n.scr = '0;
      end else if (cfg.slave) begin
         n.st = SSP_IDLE;
         sedge = (pin_i.sclk != q.sclk_d);
         samp = sedge && (pin_i.sclk == ~(pol ^ pha));
         if (pin_i.frame_select_pin) begin
            n.sact = 1'b0;
            n.cnt = '0;
         end else if (!q.sact) begin
            n.sact = 1'b1;
            load = 1'b1;
         end else if (samp) begin
            n.rsh = {q.rsh[SSP_DATA_W-2:0], pin_i.dat[0]};
            n.cnt = q.cnt + 5'h01;
            if (q.cnt + 5'h01 == bits) begin
               rx_push = 1'b1;
               rx_word = n.rsh;
               load = 1'b1;
            end
         end else if (sedge && q.cnt != 5'h00) begin
            n.sh = q.sh << 1;
         end
      end else begin
         case (q.st)
            SSP_IDLE: begin
               n.half = 1'b0;
               if (!tx_empty) begin
                  n.st = SSP_PRE;
                  load = 1'b1;
               end
            end
            SSP_PRE: begin
               if (tick) begin
                  n.half = ~q.half;
                  if (q.half) begin
                     n.st = SSP_SHIFT;
                  end
               end
            end
            SSP_SHIFT: begin
               if (tick) begin
                  n.half = ~q.half;
                  if (!q.half) begin
                     n.rsh = (q.rsh << step) | {12'h000, rx_bits};
                  end else if (q.cnt + {2'h0, step} >= bits) begin
                     rx_push = !f_rx_off(q.cur.adv);
                     rx_word = q.rsh;
                     // sticky: a later word with data queued must not wipe it
                     n.raw[SSP_INT_EOT] = q.raw[SSP_INT_EOT] | tx_empty;
                     gap = tx_empty || q.cur.eof;
                     gap = gap || (q.cur.adv != SSP_ADV_LEGACY && !cfg.frame_hold);
                     gap = gap || (cfg.fmt == SSP_FMT_SPI && !cfg.cpha && q.cur.adv == SSP_ADV_LEGACY);
                     if (gap) begin
                        n.st = SSP_GAP;
                     end else begin
                        n.st = (cfg.fmt == SSP_FMT_SYNC) ? SSP_PRE : SSP_SHIFT;
                        load = 1'b1;
                     end
                  end else begin
                     n.cnt = q.cnt + {2'h0, step};
                     n.sh = q.sh << step;
                  end
               end
            end
            SSP_GAP: begin
               // frame select stays released for a whole bit period
               if (tick) begin
                  n.half = ~q.half;
                  if (q.half) begin
                     n.st = SSP_IDLE;
                  end
               end
            end
            default: n.st = SSP_IDLE;
         endcase
      end
      // slave underrun shifts zeros rather than stalling the master
      if (load) begin
         n.cur = '0;
         if (!tx_empty) begin
            n.cur = ent;
            n.txr = q.txr + 1'b1;
         end
         n.sh = n.cur.data << (4'hf - wm1);
         n.cnt = '0;
         n.rsh = '0;
      end
      // -------------------------------------------------------------
      // fifos
      // -------------------------------------------------------------
      if (tx_valid && q.tx_ready) begin
         wr.data = tx_eof ? {SSP_EOF_HI_CLEAR, tx_data[7:0]} : tx_data;
         wr.eof = tx_eof;
         wr.adv = cfg.adv;
         n.txq[wr_idx] = wr;
         n.txw = q.txw + 1'b1;
      end
      if (rx_ready && q.rx_valid) begin
         n.rxr = q.rxr + 1'b1;
      end
      if (rx_push) begin
         if ((q.rxw - q.rxr) == CNT_FULL) begin
            n.raw[SSP_INT_OVR] = 1'b1;
         end else begin
            n.rxq[q.rxw[AW-1:0]] = rx_word;
            n.rxw = q.rxw + 1'b1;
         end
      end
      // -------------------------------------------------------------
      // status, interrupts, dma
      // -------------------------------------------------------------
      // a clear meeting a new event in the same cycle loses
      n.raw[SSP_INT_OVR] = n.raw[SSP_INT_OVR] & ~(int_clear[SSP_INT_OVR] & ~(rx_push & ~(q.rxw != n.rxw)));
      n.raw[SSP_INT_EOT] = n.raw[SSP_INT_EOT] & ~(int_clear[SSP_INT_EOT] & ~(n.st == SSP_GAP && q.st == SSP_SHIFT && tx_empty));
      n.raw[SSP_INT_TXH] = (n.txw - n.txr) <= CNT_HALF;
      n.raw[SSP_INT_RXH] = (n.rxw - n.rxr) >= CNT_HALF;
      n.masked = n.raw & int_mask;
      n.irq = |n.masked;
      n.tx_ready = (n.txw - n.txr) != CNT_FULL;
      n.rx_valid = n.rxw != n.rxr;
      n.rx_data = n.rxq[n.rxr[AW-1:0]];
      n.busy = (n.txw != n.txr) || n.st != SSP_IDLE || n.sact;
      n.dma_tx = dma_tx_en && n.tx_ready;
      n.dma_rx = dma_rx_en && n.rx_valid;
      // -------------------------------------------------------------
      // pins
      // -------------------------------------------------------------
      n.pins = '0;
      if (cfg.slave) begin
         n.pins.frame_select_pin = SSP_FS_IDLE;
         n.pins.dat = {2'h0, n.sh[15], 1'b0};
         n.pins.dat_oe = {2'h0, en && !pin_i.frame_select_pin && !cfg.slave_out_dis, 1'b0};
      end else begin
         n.pins.sclk_oe = 1'b1;
         n.pins.frame_select_pin_oe = 1'b1;
         n.pins.sclk = pol;
         if (n.st == SSP_SHIFT) begin
            n.pins.sclk = pol ^ n.half ^ pha;
         end else if (n.st == SSP_PRE && cfg.fmt == SSP_FMT_SYNC) begin
            n.pins.sclk = n.half;
         end
         if (cfg.fmt == SSP_FMT_SYNC) begin
            n.pins.frame_select_pin = (n.st == SSP_PRE);
         end else begin
            n.pins.frame_select_pin = !(n.st == SSP_PRE || n.st == SSP_SHIFT);
         end
         case (f_step(n.cur.adv))
            3'h2: n.pins.dat = {2'h0, n.sh[15:14]};
            3'h4: n.pins.dat = n.sh[15:12];
            default: n.pins.dat = {3'h0, n.sh[15]};
         endcase
         if (n.st != SSP_IDLE && !f_tx_off(n.cur.adv)) begin
            case (f_step(n.cur.adv))
               3'h2: n.pins.dat_oe = 4'h3;
               3'h4: n.pins.dat_oe = 4'hf;
               default: n.pins.dat_oe = 4'h1;
            endcase
         end
      end
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         q <= '0;
         q.raw <= SSP_INT_RST;
         q.tx_ready <= SSP_TX_READY_RST;
         q.pins.frame_select_pin <= SSP_FS_IDLE;
      end else begin
         q <= n;
      end
   end

   assign tx_ready = q.tx_ready;
   assign rx_valid = q.rx_valid;
   assign rx_data = q.rx_data;
   assign busy = q.busy;
   assign raw_status = q.raw;
   assign masked_status = q.masked;
   assign irq = q.irq;
   assign dma_tx_req = q.dma_tx;
   assign dma_rx_req = q.dma_rx;
   assign pin_o = q.pins;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   AST_FIFO_BOUND: assert property (@(posedge clk) disable iff (!nrst)
      ((q.txw - q.txr) <= CNT_FULL) && ((q.rxw - q.rxr) <= CNT_FULL))
      else $error("fifo holds more than its depth");
   AST_EOF_BYTE: assert property (@(posedge clk) disable iff (!nrst)
      (tx_valid && q.tx_ready && tx_eof) |=> q.txq[$past(wr_idx)].data[15:8] == 8'h00)
      else $error("marked write kept its upper byte");
   AST_EOF_MARK: assert property (@(posedge clk) disable iff (!nrst)
      (tx_valid && q.tx_ready) |=> q.txq[$past(wr_idx)].eof == $past(tx_eof))
      else $error("end-of-frame mark not stored with entry");
   AST_GAP_RELEASE: assert property (@(posedge clk) disable iff (!nrst)
      (q.st == SSP_GAP && !cfg.slave && cfg.fmt != SSP_FMT_SYNC) |-> q.pins.frame_select_pin)
      else $error("frame select held during gap");
   AST_DISABLE: assert property (@(posedge clk) disable iff (!nrst)
      !en |=> q.st == SSP_IDLE && !q.sact)
      else $error("shifter ran while disabled");
   AST_SLAVE_QUIET: assert property (@(posedge clk) disable iff (!nrst)
      (cfg.slave && cfg.slave_out_dis) |=> q.pins.dat_oe == 4'h0)
      else $error("slave drove data while output disabled");
   AST_BUSY: assert property (@(posedge clk) disable iff (!nrst)
      (q.txw != q.txr || q.st == SSP_SHIFT) |-> q.busy)
      else $error("not busy with work pending");
   AST_ROOM: assert property (@(posedge clk) disable iff (!nrst)
      q.tx_ready == ((q.txw - q.txr) != CNT_FULL))
      else $error("room flag disagrees with fill");
   AST_QUAD: assert property (@(posedge clk) disable iff (!nrst)
      (q.st == SSP_SHIFT && !cfg.slave && q.cur.adv == SSP_ADV_QD_WR) |-> q.pins.dat_oe == 4'hf)
      else $error("quad write not driving four lanes");
   AST_MASK: assert property (@(posedge clk) disable iff (!nrst)
      ##1 q.masked == (q.raw & $past(int_mask)))
      else $error("masked status wrong");
   AST_DMA: assert property (@(posedge clk) disable iff (!nrst)
      (!dma_tx_en && !dma_rx_en) |=> !q.dma_tx && !q.dma_rx)
      else $error("dma request while disabled");
endmodule

// File: tb/ssp_peer.sv
// serial peripheral model facing the controller in master mode
`timescale 1ns/100ps
module ssp_peer
   import ssp_pkg::*;
(
   // clock
   input wire logic clk,
   // settings
   input wire logic pha,
   input wire logic [4:0] width,
   input wire logic [15:0] reply,
   // pins
   input wire ssp_pin_out_t pin_o,
   output logic miso,
   // captured word
   output logic [15:0] got,
   output int n_got
);
   logic [15:0] sh_in = '0;
   logic [15:0] sh_out = '0;
   logic sclk_q = 1'b0;
   logic fs_q = 1'b1;
   logic seen = 1'b0;
   int nb = 0;
   initial begin
      miso = 1'b0;
      got = '0;
      n_got = 0;
   end
   // ------
   // shifter
   // ------
   always @(posedge clk) begin
      #1;
      if (fs_q && !pin_o.frame_select_pin) begin
         sh_out = reply;
         nb = 0;
         seen = 1'b0;
      end else if (!pin_o.frame_select_pin && pin_o.sclk != sclk_q) begin
         if (pin_o.sclk == !pha) begin
            sh_in = {sh_in[14:0], pin_o.dat[0]};
            nb++;
            seen = 1'b1;
            if (nb == width) begin
               got = 16'(sh_in & ((32'h1 << width) - 1));
               n_got++;
               nb = 0;
            end
         end else if (seen) begin
            sh_out = (nb == 0) ? reply : sh_out << 1;
         end
      end
      // released line must not look like held data
      miso = pin_o.frame_select_pin ? !miso : sh_out[width-1];
      sclk_q = pin_o.sclk;
      fs_q = pin_o.frame_select_pin;
   end
endmodule

// File: tb/sync_serial_port_controller_tb.sv
// self-checking bench of the serial port controller
`timescale 1ns/100ps
module sync_serial_port_controller_tb
   import ssp_pkg::*;
;
   localparam int LIM = 3000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic en = 1'b0;
   ssp_cfg_t cfg = '0;
   logic osc_tick = 1'b0;
   logic dma_tx_en = 1'b0;
   logic dma_rx_en = 1'b0;
   logic [3:0] int_mask = 4'h0;
   logic [3:0] int_clear = 4'h0;
   logic tx_valid = 1'b0;
   logic [15:0] tx_data = '0;
   logic tx_eof = 1'b0;
   logic rx_ready = 1'b0;
   logic tx_ready, rx_valid, busy, irq, dma_tx_req, dma_rx_req, miso;
   logic [15:0] rx_data, got;
   logic [3:0] raw_status, masked_status;
   ssp_pin_in_t pin_i;
   ssp_pin_out_t pin_o;
   logic m_fs = 1'b1;
   logic [15:0] reply = '0;
   logic sclk_q = 1'b0;
   logic fs_q = 1'b1;
   int n_got, n0, r0;
   int error_cnt = 0;
   int total_checks = 0;
   int cyc = 0;
   int last_rise = 0;
   int period = 0;
   int fs_rise = 0;
   int fs_up = 0;
   int fs_len = 0;
   int rises = 0;
   logic s_clk = 1'b0;
   logic s_dat = 1'b0;
   ssp_fmt_t fm [4] = '{SSP_FMT_SPI, SSP_FMT_SPI, SSP_FMT_MW, SSP_FMT_SPI};
   logic [3:0] wm [4] = '{4'h3, 4'hf, 4'h7, 4'h7};
   logic [7:0] pre [4] = '{8'h02, 8'h04, 8'h02, 8'h00};
   logic [7:0] dv [4] = '{8'h01, 8'h02, 8'h01, 8'h00};
   logic osc [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   logic [15:0] td [4] = '{16'h0009, 16'hc3a5, 16'h0081, 16'h00a5};
   logic [15:0] rp [4] = '{16'h0006, 16'h5a3c, 16'h007e, 16'h003c};
   logic [15:0] per [4] = '{16'h0004, 16'h000c, 16'h0014, 16'h0002};

   assign pin_i = '{sclk: s_clk, frame_select_pin: m_fs, dat: {2'b00, miso, s_dat}};
   always #50 clk = ~clk;

   ssp_ctrl #(.DEPTH(SSP_FIFO_DEPTH)) DUT (.clk(clk), .nrst(nrst), .en(en), .cfg(cfg),
      .precision_internal_oscillator_tick(osc_tick), .dma_tx_en(dma_tx_en), .dma_rx_en(dma_rx_en),
      .int_mask(int_mask), .int_clear(int_clear), .tx_valid(tx_valid), .tx_data(tx_data),
      .tx_eof(tx_eof), .tx_ready(tx_ready), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data), .busy(busy), .raw_status(raw_status), .masked_status(masked_status),
      .irq(irq), .dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req), .pin_i(pin_i), .pin_o(pin_o));
   ssp_peer peer (.clk(clk), .pha(cfg.cpha), .width({1'b0, cfg.width_m1} + 5'd1), .reply(reply),
      .pin_o(pin_o), .miso(miso), .got(got), .n_got(n_got));

   // ------
   // osc tick, bit period and frame monitor
   // ------
   always @(posedge clk) begin
      #1;
      cyc++;
      osc_tick = (cyc % 5 == 0);
      if (pin_o.sclk && !sclk_q) begin
         rises++;
         period = cyc - last_rise;
         last_rise = cyc;
      end
      if (pin_o.frame_select_pin && !fs_q) begin
         fs_rise++;
         fs_up = cyc;
      end
      if (!pin_o.frame_select_pin && fs_q) fs_len = cyc - fs_up;
      sclk_q = pin_o.sclk;
      fs_q = pin_o.frame_select_pin;
   end

   // ------
   // tasks
   // ------
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic finish_test();
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic guard(input int k);
      if (k >= LIM) begin
         error_cnt++;
         $display("MISMATCH wait expected done seen timeout");
         finish_test();
      end
   endtask
   function automatic logic [15:0] msk();
      return 16'((32'h1 << (cfg.width_m1 + 1)) - 1);
   endfunction
   task automatic push(input logic [15:0] d, input logic e);
      int k;
      k = 0;
      tx_valid = 1'b1;
      tx_data = d;
      tx_eof = e;
      while (tx_ready !== 1'b1 && k < LIM) begin
         step(1);
         k++;
      end
      guard(k);
      step(1);
      tx_valid = 1'b0;
      step(1);
   endtask
   task automatic wait_idle();
      int k;
      k = 0;
      while (busy !== 1'b0 && k < LIM) begin
         step(1);
         k++;
      end
      guard(k);
   endtask
   task automatic pop(input logic [15:0] exp, input logic chk);
      int k;
      k = 0;
      while (rx_valid !== 1'b1 && k < LIM) begin
         step(1);
         k++;
      end
      guard(k);
      if (chk) check("rx word", exp, rx_data);
      rx_ready = 1'b1;
      step(1);
      rx_ready = 1'b0;
      step(1);
   endtask
   task automatic xfer(input logic [15:0] d, input logic [15:0] r);
      n0 = n_got;
      reply = r;
      push(d, 1'b0);
      wait_idle();
      check("peer count", 16'(n0 + 1), 16'(n_got));
      check("peer word", d & msk(), got);
      pop(r & msk(), 1'b1);
   endtask

   // ------
   // sequence
   // ------
   initial begin
      step(3);
      check("reset outs", {SSP_TX_READY_RST, 5'h00, SSP_FS_IDLE, 1'b0, SSP_INT_RST, 4'h0}, {tx_ready, rx_valid,
         busy, irq, dma_tx_req, dma_rx_req, pin_o.frame_select_pin, pin_o.sclk, raw_status, masked_status});
      step(3);
      nrst = 1'b1;
      en = 1'b1;
      step(1);
      for (int i = 0; i < 4; i++) begin
         cfg.fmt = fm[i];
         cfg.width_m1 = wm[i];
         cfg.prescale = pre[i];
         cfg.divider = dv[i];
         cfg.bit_clock_from_internal_osc = osc[i];
         xfer(td[i], rp[i]);
         check("bit period", per[i], 16'(period));
      end
      cfg.fmt = SSP_FMT_SYNC;
      push(16'h005a, 1'b0);
      wait_idle();
      check("sync word", 16'h0001, 16'(rx_valid));
      pop('0, 1'b0);
      cfg.fmt = SSP_FMT_SPI;
      // fill while stopped so the refusal is seen
      en = 1'b0;
      reply = 16'h0042;
      dma_tx_en = 1'b1;
      dma_rx_en = 1'b1;
      int_mask = 4'hf;
      for (int i = 1; i <= SSP_FIFO_DEPTH; i++) push(16'(i * 16'h11), 1'b0);
      check("tx room", 16'h0, 16'({tx_ready, dma_tx_req}));
      tx_valid = 1'b1;
      tx_data = 16'h00ff;
      step(1);
      tx_valid = 1'b0;
      n0 = n_got;
      en = 1'b1;
      step(1);
      wait_idle();
      step(2);
      check("peer count", 16'(n0 + 8), 16'(n_got));
      check("last word", 16'h0088, got);
      check("status", 16'hbb13, {raw_status, masked_status, 3'h0, irq, 2'h0, dma_tx_req, dma_rx_req});
      push(16'h0099, 1'b0);
      wait_idle();
      step(2);
      check("overrun", 16'h000f, 16'(raw_status));
      int_clear = 4'hc;
      step(1);
      int_clear = 4'h0;
      int_mask = 4'h0;
      step(3);
      check("cleared", 16'h3000, {raw_status, masked_status, 7'h0, irq});
      for (int i = 0; i < SSP_FIFO_DEPTH; i++) pop(16'h0042, 1'b1);
      dma_tx_en = 1'b0;
      step(2);
      check("drained", 16'h1000, {raw_status, 3'h0, rx_valid, 6'h0, dma_tx_req, dma_rx_req});
      cfg.cpha = 1'b1;
      cfg.width_m1 = 4'hf;
      push(16'hbe5a, 1'b1);
      wait_idle();
      check("eof word", 16'h005a, got);
      pop(16'h0042, 1'b1);
      for (int e = 0; e < 2; e++) begin
         r0 = fs_rise;
         push(16'h1111, e[0]);
         push(16'h2222, 1'b0);
         wait_idle();
         check("releases", 16'(e + 1), 16'(fs_rise - r0));
         pop(16'h0042, 1'b1);
         pop(16'h0042, 1'b1);
      end
      check("gap length", 16'h0001, 16'(fs_len >= period));
      // advanced words: eight bits, mode zero, four lanes
      cfg.cpha = 1'b0;
      cfg.width_m1 = 4'h7;
      cfg.adv = SSP_ADV_QD_WR;
      for (int h = 0; h < 2; h++) begin
         cfg.frame_hold = h[0];
         r0 = fs_rise;
         n0 = rises;
         push(16'h00c3, 1'b0);
         push(16'h003c, 1'b0);
         wait_idle();
         check("adv releases", 16'(2 - h), 16'(fs_rise - r0));
         check("quad clocks", 16'h0004, 16'(rises - n0));
      end
      cfg.adv = SSP_ADV_LEGACY;
      cfg.slave = 1'b1;
      m_fs = 1'b0;
      step(3);
      check("slave out", 16'h0001, 16'(pin_o.dat_oe[1]));
      // external master clocks one mode-zero word in
      for (int b = 7; b >= 0; b--) begin
         s_dat = td[3][b];
         step(1);
         s_clk = 1'b1;
         step(1);
         s_clk = 1'b0;
      end
      pop(td[3], 1'b1);
      cfg.slave_out_dis = 1'b1;
      step(3);
      check("slave off", 16'h0, 16'(pin_o.dat_oe[1]));
      cfg.slave_out_dis = 1'b0;
      en = 1'b0;
      step(3);
      check("stopped", 16'h0, 16'(pin_o.dat_oe[1]));
      m_fs = 1'b1;
      cfg.slave = 1'b0;
      en = 1'b1;
      step(1);
      push(16'hffff, 1'b0);
      step(4);
      en = 1'b0;
      step(3);
      check("abort", 16'({1'b0, SSP_FS_IDLE}), 16'({busy, pin_o.frame_select_pin}));
      finish_test();
   end
endmodule
